// ---- core/ros_top.sv ----
/*
  Relay output source select for sixteen channel slots: per-slot relay
  state word, status word, source register and module id readback, and
  the periodic copy of each selected discrete signal to the relay drive.
  Assumes a single 125 MHz clock and inputs synchronous to it.
*/
`timescale 1ns/1ps
module ros_top (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic [3:0] reg_chan_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic [127:0] slot_module_id_in,
  input wire logic onboard_relay_first_in,
  input wire logic onboard_relay_second_in,
  input wire logic [95:0] digital_output_flag_in,
  input wire logic [15:0] advanced_setpoint_relay_in,
  input wire logic [127:0] setpoint_union_mask_in,
  input wire logic [3:0] onboard_input_line_in,
  input wire logic [95:0] expansion_input_flag_in,
  input wire logic [15:0] control_input_flag_in,
  output logic [15:0] relay_mode_out,
  output logic [15:0] relay_drive_out
);

  // ----------------------------------------------------------------------
  // Slot state
  // ----------------------------------------------------------------------
  logic [15:0] fitted;
  logic [15:0] state;
  logic [15:0] sel_bit;
  logic [15:0] sel_valid;
  logic [15:0] source [16];
  logic [15:0] status [16];
  logic [7:0] tick_cnt;
  logic tick;

  always_comb begin
    for (int i = 0; i < ros_pkg::CHANNELS; i++) begin
      fitted[i] = slot_module_id_in[i*8 +: 8] ==
                  ros_pkg::RELAY_MODULE_ID;
      status[i] = 16'h0000;
      status[i][ros_pkg::ST_FITTED] = fitted[i];
      status[i][ros_pkg::ST_SRC_VALID] = sel_valid[i];
      status[i][ros_pkg::ST_DRIVE] = relay_drive_out[i];
      status[i][ros_pkg::ST_SRC_RESERVED] = ~sel_valid[i] &
                                            (source[i] != 16'h0000);
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_dec
    ros_decode u_dec (
      .code_in(source[g]),
      .onboard_relay_first_in(onboard_relay_first_in),
      .onboard_relay_second_in(onboard_relay_second_in),
      .slot_relay_in(state),
      .slot_fitted_in(fitted),
      .digital_output_flag_in(digital_output_flag_in),
      .advanced_setpoint_relay_in(advanced_setpoint_relay_in),
      .setpoint_union_mask_in(setpoint_union_mask_in),
      .onboard_input_line_in(onboard_input_line_in),
      .expansion_input_flag_in(expansion_input_flag_in),
      .control_input_flag_in(control_input_flag_in),
      .level_out(sel_bit[g]),
      .valid_out(sel_valid[g])
    );
  end

  // ----------------------------------------------------------------------
  // Update tick
  // ----------------------------------------------------------------------
  assign tick = tick_cnt == ros_pkg::UPDATE_LAST;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt <= 8'h00;
    end else if (tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Relay state words
  // ----------------------------------------------------------------------
  // A software write lands after the tick copy, so it wins for one update
  // period; the next tick overwrites it if a valid source is selected.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= 16'h0000;
    end else begin
      for (int i = 0; i < ros_pkg::CHANNELS; i++) begin
        if (tick && fitted[i] && sel_valid[i]) begin
          state[i] <= sel_bit[i];
        end
      end
      if (reg_wr_in && reg_sel_in == ros_pkg::SEL_VALUE &&
          fitted[reg_chan_in]) begin
        state[reg_chan_in] <= reg_wdata_in[0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < ros_pkg::CHANNELS; i++) begin
        source[i] <= ros_pkg::SOURCE_RESET;
      end
    end else if (reg_wr_in && reg_sel_in == ros_pkg::SEL_SOURCE) begin
      source[reg_chan_in] <= reg_wdata_in[15:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      relay_drive_out <= 16'h0000;
      relay_mode_out <= 16'h0000;
    end else begin
      relay_drive_out <= state & fitted;
      relay_mode_out <= fitted;
    end
  end

  // ----------------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h00000000;
      reg_ack_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      if (reg_rd_in) begin
        case (reg_sel_in)
          ros_pkg::SEL_VALUE: begin
            reg_rdata_out <= {31'h00000000,
                              state[reg_chan_in] & fitted[reg_chan_in]};
          end
          ros_pkg::SEL_STATUS: begin
            reg_rdata_out <= fitted[reg_chan_in] ?
                             {16'h0000, status[reg_chan_in]} :
                             32'h00000000;
          end
          ros_pkg::SEL_SOURCE: begin
            reg_rdata_out <= {16'h0000, source[reg_chan_in]};
          end
          default: begin
            reg_rdata_out <= {24'h000000,
                              slot_module_id_in[reg_chan_in*8 +: 8]};
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_tick_then_quiet;
    tick ##1 !tick [*8];
  endsequence

  a_drive_fitted_only: assert property (
    ##1 (relay_drive_out & ~$past(fitted)) == 16'h0000)
    else $error("relay driven in a slot without relay module");
  a_tick_spacing: assert property (tick |-> s_tick_then_quiet)
    else $error("update ticks too close together");
  a_update_copy: assert property (
    tick && fitted[0] && sel_valid[0] &&
    !(reg_wr_in && reg_sel_in == ros_pkg::SEL_VALUE && reg_chan_in == 0)
    |=> state[0] == $past(sel_bit[0]))
    else $error("selected source not copied on update");
  a_reserved_hold: assert property (
    !sel_valid[0] && !(reg_wr_in && reg_chan_in == 0)
    |=> $stable(state[0]))
    else $error("invalid source changed the relay state");
  a_status_read: assert property (
    reg_rd_in && reg_sel_in == ros_pkg::SEL_STATUS && fitted[reg_chan_in]
    |=> reg_ack_out && reg_rdata_out[15:0] == $past(status[reg_chan_in]))
    else $error("status word readback wrong");
  a_value_binary: assert property (
    reg_rd_in && reg_sel_in == ros_pkg::SEL_VALUE
    |=> reg_rdata_out[31:1] == 31'h00000000)
    else $error("channel value not zero or one");
  a_unfitted_zero: assert property (
    reg_rd_in && reg_sel_in != ros_pkg::SEL_SOURCE &&
    reg_sel_in != ros_pkg::SEL_MODULE_ID && !fitted[reg_chan_in]
    |=> reg_rdata_out == 32'h00000000)
    else $error("relay register live in an unfitted slot");
  a_id_read: assert property (
    reg_rd_in && reg_sel_in == ros_pkg::SEL_MODULE_ID
    |=> reg_rdata_out[7:0] == $past(slot_module_id_in[reg_chan_in*8 +: 8]))
    else $error("module id readback wrong");
  a_onboard_pick: assert property (
    source[0] == ros_pkg::SRC_RELAY_FIRST
    |-> sel_valid[0] && sel_bit[0] == onboard_relay_first_in)
    else $error("code one does not pick the first onboard relay");
  a_source_store: assert property (
    reg_wr_in && reg_sel_in == ros_pkg::SEL_SOURCE
    |=> source[$past(reg_chan_in)] == $past(reg_wdata_in[15:0]))
    else $error("source register not written");

endmodule : ros_top

// ---- core/ros_pkg.sv ----
/*
  Shared constants for the relay output source select block: register
  selectors, discrete source code ranges, status word layout and timing.
  Assumes a single 125 MHz system clock.
*/
package ros_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int CHANNELS = 16;
  localparam int ID_W = 8;
  localparam int SRC_W = 16;
  localparam int VALUE_W = 32;
  localparam int STATUS_W = 16;

  // Module identification code of a relay module; value is arbitrary.
  localparam logic [7:0] RELAY_MODULE_ID = 8'h5a;

  // ----------------------------------------------------------------------
  // Register selectors on the register port
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_VALUE = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_SOURCE = 2'h2;
  localparam logic [1:0] SEL_MODULE_ID = 2'h3;
  localparam logic [15:0] SOURCE_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------------
  localparam int ST_FITTED = 0;
  localparam int ST_SRC_VALID = 1;
  localparam int ST_DRIVE = 2;
  localparam int ST_SRC_RESERVED = 3;

  // ----------------------------------------------------------------------
  // Discrete source code ranges
  // ----------------------------------------------------------------------
  localparam logic [15:0] SRC_RELAY_FIRST = 16'h0001;
  localparam logic [15:0] SRC_RELAY_SECOND = 16'h0002;
  localparam logic [15:0] SRC_SLOT_LO = 16'h0003;
  localparam logic [15:0] SRC_SLOT_HI = 16'h0010;
  localparam logic [15:0] SRC_DOUT_LO = 16'h0011;
  localparam logic [15:0] SRC_DOUT_HI = 16'h0070;
  localparam logic [15:0] SRC_ASP_LO = 16'h0071;
  localparam logic [15:0] SRC_ASP_HI = 16'h0080;
  localparam logic [15:0] SRC_MASK_LO = 16'h0101;
  localparam logic [15:0] SRC_MASK_HI = 16'h0108;
  localparam logic [15:0] SRC_ONB_LO = 16'h8001;
  localparam logic [15:0] SRC_ONB_HI = 16'h8004;
  localparam logic [15:0] SRC_EXP_LO = 16'h8011;
  localparam logic [15:0] SRC_EXP_HI = 16'h8070;
  localparam logic [15:0] SRC_CI_LO = 16'h8071;
  localparam logic [15:0] SRC_CI_HI = 16'h8080;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int UPDATE_PERIOD_NS = 1000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] UPDATE_LAST = 8'(UPDATE_CYCLES - 1);

  function automatic logic in_range(input logic [15:0] code,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (code >= lo) && (code <= hi);
  endfunction : in_range

endpackage : ros_pkg

// ---- core/ros_decode.sv ----
/*
  Decodes one 16-bit discrete source code into the selected signal level.
  Assumes all discrete inputs are synchronous to the system clock.
*/
`timescale 1ns/1ps
module ros_decode (
  input wire logic [15:0] code_in,
  input wire logic onboard_relay_first_in,
  input wire logic onboard_relay_second_in,
  input wire logic [15:0] slot_relay_in,
  input wire logic [15:0] slot_fitted_in,
  input wire logic [95:0] digital_output_flag_in,
  input wire logic [15:0] advanced_setpoint_relay_in,
  input wire logic [127:0] setpoint_union_mask_in,
  input wire logic [3:0] onboard_input_line_in,
  input wire logic [95:0] expansion_input_flag_in,
  input wire logic [15:0] control_input_flag_in,
  output logic level_out,
  output logic valid_out
);

  logic [15:0] off;
  logic [15:0] mask_word;

  always_comb begin
    level_out = 1'b0;
    valid_out = 1'b1;
    off = 16'h0000;
    mask_word = 16'h0000;
    if (code_in == ros_pkg::SRC_RELAY_FIRST) begin
      level_out = onboard_relay_first_in;
    end else if (code_in == ros_pkg::SRC_RELAY_SECOND) begin
      level_out = onboard_relay_second_in;
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_SLOT_LO,
                                   ros_pkg::SRC_SLOT_HI)) begin
      // A slot relay exists only while its slot holds a relay module.
      off = code_in - 16'h0001;
      valid_out = slot_fitted_in[off[3:0]];
      level_out = slot_fitted_in[off[3:0]] & slot_relay_in[off[3:0]];
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_DOUT_LO,
                                   ros_pkg::SRC_DOUT_HI)) begin
      off = code_in - ros_pkg::SRC_DOUT_LO;
      level_out = digital_output_flag_in[off[6:0]];
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_ASP_LO,
                                   ros_pkg::SRC_ASP_HI)) begin
      off = code_in - ros_pkg::SRC_ASP_LO;
      level_out = advanced_setpoint_relay_in[off[3:0]];
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_MASK_LO,
                                   ros_pkg::SRC_MASK_HI)) begin
      off = code_in - ros_pkg::SRC_MASK_LO;
      mask_word = setpoint_union_mask_in[{off[2:0], 4'h0} +: 16];
      level_out = |(mask_word & advanced_setpoint_relay_in);
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_ONB_LO,
                                   ros_pkg::SRC_ONB_HI)) begin
      off = code_in - ros_pkg::SRC_ONB_LO;
      level_out = onboard_input_line_in[off[1:0]];
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_EXP_LO,
                                   ros_pkg::SRC_EXP_HI)) begin
      off = code_in - ros_pkg::SRC_EXP_LO;
      level_out = expansion_input_flag_in[off[6:0]];
    end else if (ros_pkg::in_range(code_in, ros_pkg::SRC_CI_LO,
                                   ros_pkg::SRC_CI_HI)) begin
      off = code_in - ros_pkg::SRC_CI_LO;
      level_out = control_input_flag_in[off[3:0]];
    end else begin
      // Code zero, reserved codes and analogue numbers select nothing.
      valid_out = 1'b0;
    end
  end

endmodule : ros_decode

// ---- sim/ros_slot_model.sv ----
/*
  Model of the plug-in modules in the sixteen channel slots: each slot
  presents its module id, a relay module where fitted_in is set.
  Assumes the bench changes fitted_in only between register accesses.
*/
`timescale 1ns/1ps
module ros_slot_model (
  input wire logic [15:0] fitted_in,
  output logic [127:0] slot_module_id_out
);
  // ----------------------------------------------------------------------
  // Module ids
  // ----------------------------------------------------------------------
  // Id of a non-relay module; value is arbitrary.
  localparam logic [7:0] OTHER_ID = 8'h33;

  // A slot swaps id at once, as a module hot-plugged between accesses.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      slot_module_id_out[i*8+:8] = fitted_in[i] ? ros_pkg::RELAY_MODULE_ID
                                                : OTHER_ID;
    end
  end
endmodule : ros_slot_model

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the relay output source select block.
  Assumes a 125 MHz clock and an update tick every 125 cycles.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [1:0] reg_sel_in = 2'h0;
  logic [3:0] reg_chan_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd;
  logic reg_ack_out;
  logic [127:0] slot_module_id_in, mask_in = 128'h0;
  logic relay_a = 1'b0, relay_b = 1'b0;
  logic [95:0] dout_in = 96'h0, exp_in = 96'h0;
  logic [15:0] asp_in = 16'h0, ci_in = 16'h0, mode, drive;
  logic [3:0] onb_in = 4'h0;
  logic [15:0] fitted = 16'hb5a7, code;
  logic [15:0] exp_state = 16'h0;
  logic [1:0] vl;
  int failures = 0, cmp_count = 0;

  ros_slot_model ros_slot_model_i (.fitted_in(fitted),
    .slot_module_id_out(slot_module_id_in));
  ros_top ros_top_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_sel_in(reg_sel_in),
    .reg_chan_in(reg_chan_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .slot_module_id_in(slot_module_id_in),
    .onboard_relay_first_in(relay_a), .onboard_relay_second_in(relay_b),
    .digital_output_flag_in(dout_in), .advanced_setpoint_relay_in(asp_in),
    .setpoint_union_mask_in(mask_in), .onboard_input_line_in(onb_in),
    .expansion_input_flag_in(exp_in), .control_input_flag_in(ci_in),
    .relay_mode_out(mode), .relay_drive_out(drive));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // One access: request held for one edge, answer taken 1 ns after that same edge.
  task automatic reg_op(input logic wr, input logic [1:0] sel,
                        input logic [3:0] ch, input logic [31:0] wd);
    @(posedge clk_sys_in);
    #1;
    {reg_wr_in, reg_rd_in} = {wr, ~wr};
    {reg_sel_in, reg_chan_in, reg_wdata_in} = {sel, ch, wd};
    @(posedge clk_sys_in);
    #1;
    {reg_wr_in, reg_rd_in} = 2'b00;
    rd = reg_rdata_out;
    check("ack", 32'h1, {31'h0, reg_ack_out});
  endtask : reg_op

  // Expected {valid, level} of a source code from the bench's inputs.
  function automatic logic [1:0] expect_src(input logic [15:0] c);
    if (c == 16'h1) return {1'b1, relay_a};
    if (c == 16'h2) return {1'b1, relay_b};
    if (c >= 3 && c <= 16) return {fitted[c-1], exp_state[c-1]};
    if (c >= 17 && c <= 112) return {1'b1, dout_in[c-17]};
    if (c >= 113 && c <= 128) return {1'b1, asp_in[c-113]};
    if (c >= 257 && c <= 264) return {1'b1, |(asp_in & mask_in[(c-257)*16+:16])};
    if (c >= 32769 && c <= 32772) return {1'b1, onb_in[c-32769]};
    if (c >= 32785 && c <= 32880) return {1'b1, exp_in[c-32785]};
    if (c >= 32881 && c <= 32896) return {1'b1, ci_in[c-32881]};
    return 2'b00;
  endfunction : expect_src

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    #400000;
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(89));
    repeat (12) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check("mode", {16'h0, fitted}, {16'h0, mode});
    check("drive", 32'h0, {16'h0, drive});
    for (int i = 0; i < 16; i++) begin
      reg_op(1'b0, ros_pkg::SEL_MODULE_ID, 4'(i), 32'h0);
      check("id", {24'h0, slot_module_id_in[i*8+:8]}, rd);
      vl[0] = 1'($urandom);
      reg_op(1'b1, ros_pkg::SEL_VALUE, 4'(i), {31'h7fff_ffff, vl[0]});
      exp_state[i] = fitted[i] & vl[0];
      reg_op(1'b0, ros_pkg::SEL_VALUE, 4'(i), 32'h0);
      check("value", {31'h0, exp_state[i]}, rd);
    end
    repeat (3) @(posedge clk_sys_in);
    check("drive", {16'h0, exp_state}, {16'h0, drive});
    for (int it = 0; it < 36; it++) begin
      {relay_a, relay_b, onb_in} = 6'($urandom);
      {asp_in, ci_in} = $urandom;
      dout_in = {$urandom, $urandom, $urandom};
      exp_in = {$urandom, $urandom, $urandom};
      mask_in = {$urandom, $urandom, $urandom, $urandom};
      case (it % 9)
        0: code = 16'h1;
        1: code = 16'h2;
        2: code = 16'(3 + $urandom_range(0, 13));
        3: code = 16'(17 + $urandom_range(0, 95));
        4: code = 16'(113 + $urandom_range(0, 15));
        5: code = 16'(257 + $urandom_range(0, 7));
        6: code = 16'(32769 + $urandom_range(0, 3));
        7: code = 16'(32785 + $urandom_range(0, 95));
        default: code = 16'(32881 + $urandom_range(0, 15));
      endcase
      if (it < 9) code = (it % 3 == 0) ? 16'h8070 : code;
      reg_op(1'b1, ros_pkg::SEL_SOURCE, 4'h0, {16'hffff, code});
      reg_op(1'b0, ros_pkg::SEL_SOURCE, 4'h0, 32'h0);
      check("source", {16'h0, code}, rd);
      vl = expect_src(code);
      if (vl[1]) exp_state[0] = vl[0];
      repeat (260) @(posedge clk_sys_in);
      check("drive0", {31'h0, exp_state[0]}, {31'h0, drive[0]});
      reg_op(1'b0, ros_pkg::SEL_STATUS, 4'h0, 32'h0);
      check("status", {28'h0, ~vl[1], exp_state[0], vl[1], 1'b1}, rd);
    end
    // Codes past the source table select nothing and keep the value; the
    // reserved ranges inside the table are never written.
    for (int k = 0; k < 3; k++) begin
      code = (k == 0) ? 16'h8081 : (k == 1) ? 16'hc000 : 16'hffff;
      reg_op(1'b1, ros_pkg::SEL_SOURCE, 4'h0, {16'h0, code});
      reg_op(1'b1, ros_pkg::SEL_VALUE, 4'h0, 32'(k[0]));
      repeat (260) @(posedge clk_sys_in);
      check("held", {31'h0, k[0]}, {31'h0, drive[0]});
      reg_op(1'b0, ros_pkg::SEL_STATUS, 4'h0, 32'h0);
      check("rsv", {28'h0, 1'b1, k[0], 2'b01}, rd);
    end
    reg_op(1'b0, ros_pkg::SEL_STATUS, 4'h3, 32'h0);
    check("unfit", 32'h0, rd);
    fitted[3] = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check("swap", {16'h0, fitted}, {16'h0, mode});
    reg_op(1'b1, ros_pkg::SEL_VALUE, 4'h3, 32'h1);
    reg_op(1'b0, ros_pkg::SEL_VALUE, 4'h3, 32'h0);
    check("value3", 32'h1, rd);
    summarize();
  end
endmodule : testbench
